/* File: verilog/pmtr_pkg.sv */
// Constants and types shared by the program memory and table read block
package pmtr_pkg;
   // ==========================================================
   // Program store
   localparam int unsigned PROG_WORDS = 49152;
   localparam logic [15:0] PROG_LAST = 16'hBFFF;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   // ==========================================================
   // Nonvolatile data memory
   localparam int unsigned EE_WORDS = 256;
   // ==========================================================
   // Table read destination layout
   localparam int unsigned DEST_W = 11;
   localparam int unsigned SECT_LSB = 8;
   localparam logic [2:0] SECTOR_ZERO = 3'h0;
   // ==========================================================
   // Instruction cycle timing
   localparam int unsigned SYS_CLK_NS = 100;
   localparam int unsigned INSTR_NS = 400;
   localparam int unsigned CYCLE_CLKS = INSTR_NS / SYS_CLK_NS;
   localparam logic [1:0] TICK_LAST = 2'(CYCLE_CLKS - 1);
   // ==========================================================
   // Serial frame: read flag, target flag, 16 address, 16 data
   localparam logic [5:0] HDR_LAST = 6'h11;
   localparam logic [5:0] FRAME_LAST = 6'h21;
   localparam logic [5:0] FRAME_BITS = 6'h22;
   localparam logic [5:0] DATA_FIRST = 6'h12;
   // ==========================================================
   // Table read sequencer states
   typedef enum logic [1:0] {TR_IDLE, TR_CYC1, TR_CYC2} pmtr_trd_t;
endpackage : pmtr_pkg

/* File: verilog/pmtr_top.sv */
// Program store, table read sequencer and serial programming port
`timescale 1ns/1ps
module pmtr_top import pmtr_pkg::*; (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic pcLoad,
   input wire logic [15:0] pcTarget,
   output logic cycleTick,
   output logic [15:0] progCounter,
   output logic [15:0] fetchWord,
   input wire logic ptrWrLow,
   input wire logic ptrWrHigh,
   input wire logic [7:0] ptrWrData,
   output logic [7:0] tablePtrLow,
   output logic [7:0] tablePtrHigh,
   input wire logic tabrdReq,
   input wire logic tabrdExt,
   input wire logic [10:0] tabrdDest,
   output logic tableBusy,
   output logic tabrdFault,
   output logic destWrEn,
   output logic [10:0] destWrAddr,
   output logic [7:0] destWrData,
   input wire logic latchWrEn,
   input wire logic [7:0] latchWrData,
   output logic [7:0] tableDataHighLatch,
   input wire logic progEntryPin,
   input wire logic debugMode,
   input wire logic progSerialClockPin,
   input wire logic progSerialDataIn,
   output logic progSerialDataOut,
   output logic progSerialDataOe,
   input wire logic sharedFuncOut,
   input wire logic sharedFuncOe,
   output logic progActive
);
   // ==========================================================
   // Storage
   logic [15:0] progMem [0:PROG_WORDS-1];
   logic [7:0] eeMem [0:EE_WORDS-1];
   // ==========================================================
   // Instruction cycle divider and program counter
   logic [1:0] clkDiv;
   wire tickNow = (clkDiv == TICK_LAST);
   wire pcInRange = (progCounter <= PROG_LAST);
   wire [15:0] pcInc = (progCounter >= PROG_LAST) ? RESET_VECTOR
                                                 : progCounter + 16'h0001;
   wire [15:0] next_pc = pcLoad ? pcTarget : pcInc;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkDiv <= 2'h0;
         cycleTick <= 1'b0;
      end else begin
         clkDiv <= tickNow ? 2'h0 : clkDiv + 2'h1;
         cycleTick <= tickNow;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         progCounter <= RESET_VECTOR;
         fetchWord <= 16'h0000;
      end else if (cycleTick && !progActive) begin
         fetchWord <= pcInRange ? progMem[progCounter] : 16'h0000;
         progCounter <= next_pc;
      end
   end
   // ==========================================================
   // Table pointer and table read sequencer
   pmtr_trd_t trState;
   wire [15:0] tableAddr = {tablePtrHigh, tablePtrLow};
   wire tableInRange = (tableAddr <= PROG_LAST);
   wire [15:0] tableWord = tableInRange ? progMem[tableAddr] : 16'h0000;
   wire [2:0] destSector = tabrdDest[DEST_W-1:SECT_LSB];
   wire sectorOk = tabrdExt || (destSector == SECTOR_ZERO);
   wire reqIdle = tabrdReq && (trState == TR_IDLE);
   wire accept = reqIdle && sectorOk;
   wire finish = (trState == TR_CYC2) && cycleTick;
   logic [10:0] destHold;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tablePtrLow <= 8'h00;
         tablePtrHigh <= 8'h00;
      end else begin
         // Only software writes move the pointer
         if (ptrWrLow) tablePtrLow <= ptrWrData;
         if (ptrWrHigh) tablePtrHigh <= ptrWrData;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         trState <= TR_IDLE;
         destHold <= 11'h000;
         tabrdFault <= 1'b0;
      end else begin
         tabrdFault <= reqIdle && !sectorOk;
         unique case (trState)
            TR_IDLE: begin
               if (accept) begin
                  trState <= TR_CYC1;
                  destHold <= tabrdDest;
               end
            end
            TR_CYC1: if (cycleTick) trState <= TR_CYC2;
            TR_CYC2: if (cycleTick) trState <= TR_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tableBusy <= 1'b0;
         destWrEn <= 1'b0;
         destWrAddr <= 11'h000;
         destWrData <= 8'h00;
         tableDataHighLatch <= 8'h00;
      end else begin
         tableBusy <= accept || ((trState != TR_IDLE) && !finish);
         destWrEn <= finish;
         if (finish) begin
            destWrAddr <= destHold;
            destWrData <= tableWord[BYTE_W-1:0];
            tableDataHighLatch <= tableWord[WORD_W-1:BYTE_W];
         end else if (latchWrEn) begin
            tableDataHighLatch <= latchWrData;
         end
      end
   end
   // ==========================================================
   // Pin synchronisers, a change counts once stages two and three agree
   logic [2:0] ckSync, daSync, enSync;
   logic ckF, daF;
   wire next_ckF = (ckSync[1] == ckSync[2]) ? ckSync[2] : ckF;
   wire next_daF = (daSync[1] == daSync[2]) ? daSync[2] : daF;
   wire next_en = (enSync[1] == enSync[2]) ? enSync[2] : progActive;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ckSync <= 3'h0;
         daSync <= 3'h0;
         enSync <= 3'h0;
         ckF <= 1'b0;
         daF <= 1'b0;
         progActive <= 1'b0;
      end else begin
         ckSync <= {ckSync[1:0], progSerialClockPin};
         daSync <= {daSync[1:0], progSerialDataIn};
         enSync <= {enSync[1:0], progEntryPin};
         ckF <= next_ckF;
         daF <= next_daF;
         progActive <= next_en;
      end
   end
   // ==========================================================
   // Serial engine shared by programming and debug
   wire serOwns = progActive || debugMode;
   wire ckRise = serOwns && !ckF && next_ckF;
   wire ckFall = serOwns && ckF && !next_ckF;
   logic [5:0] bitCnt;
   logic [17:0] shiftIn;
   logic [15:0] outShift, serAddr;
   logic serRead, serTgt, loadNow, wrNow, serOut;
   wire hdrDone = ckRise && (bitCnt == HDR_LAST);
   wire frameDone = ckRise && (bitCnt == FRAME_LAST);
   wire [15:0] hdrAddr = shiftIn[15:0];
   wire hdrProgOk = (hdrAddr <= PROG_LAST);
   wire [15:0] progRd = hdrProgOk ? progMem[hdrAddr] : 16'h0000;
   wire [15:0] memRd = shiftIn[16] ? {8'h00, eeMem[hdrAddr[7:0]]} : progRd;
   wire readPhase = serRead && (bitCnt >= DATA_FIRST) && (bitCnt < FRAME_BITS);
   wire serOe = serOwns && readPhase;
   wire next_pinOut = serOwns ? serOut : sharedFuncOut;
   wire next_pinOe = serOwns ? serOe : sharedFuncOe;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt <= 6'h00;
         shiftIn <= 18'h0_0000;
         loadNow <= 1'b0;
         wrNow <= 1'b0;
      end else begin
         loadNow <= hdrDone;
         wrNow <= frameDone;
         if (!serOwns) begin
            bitCnt <= 6'h00;
         end else if (ckRise) begin
            shiftIn <= {shiftIn[16:0], daF};
            if (bitCnt < FRAME_BITS) bitCnt <= bitCnt + 6'h01;
            else bitCnt <= 6'h01;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         serRead <= 1'b0;
         serTgt <= 1'b0;
         serAddr <= 16'h0000;
         outShift <= 16'h0000;
         serOut <= 1'b0;
      end else if (loadNow) begin
         serRead <= shiftIn[17];
         serTgt <= shiftIn[16];
         serAddr <= hdrAddr;
         outShift <= {memRd[14:0], 1'b0};
         serOut <= memRd[15];
      end else if (ckFall && readPhase) begin
         serOut <= outShift[15];
         outShift <= {outShift[14:0], 1'b0};
      end else if (wrNow) begin
         // Frame over, so the next header never sees a stale read flag
         serRead <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (wrNow && !serRead && !serTgt && serAddr <= PROG_LAST)
         progMem[serAddr] <= shiftIn[15:0];
      if (wrNow && !serRead && serTgt)
         eeMem[serAddr[7:0]] <= shiftIn[7:0];
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         progSerialDataOut <= 1'b0;
         progSerialDataOe <= 1'b0;
      end else begin
         progSerialDataOut <= next_pinOut;
         progSerialDataOe <= next_pinOe;
      end
   end
   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic fetched;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) fetched <= 1'b0;
      else if (cycleTick) fetched <= 1'b1;
   end
   a_reset_vector_start: assert property (
      (!fetched && cycleTick) |-> progCounter == RESET_VECTOR)
      else $error("first fetch not at reset vector");
   a_tick_four_clocks: assert property (
      cycleTick |=> !cycleTick [*3] ##1 cycleTick)
      else $error("instruction cycle not four clocks");
   a_table_two_cycles: assert property (
      accept |-> ##[6:9] destWrEn)
      else $error("table read not done in two cycles");
   a_table_busy_span: assert property (
      accept |=> tableBusy [*4])
      else $error("table read busy dropped early");
   a_table_data_bytes: assert property (
      destWrEn |-> {tableDataHighLatch, destWrData} == $past(tableWord)
                   && destWrAddr == $past(destHold))
      else $error("table word bytes misrouted");
   a_sector_fault: assert property (
      (reqIdle && !tabrdExt && destSector != SECTOR_ZERO)
      |=> tabrdFault && !tableBusy)
      else $error("ordinary read to other sector accepted");
   a_latch_sw_write: assert property (
      (latchWrEn && !finish) |=> tableDataHighLatch == $past(latchWrData))
      else $error("latch write lost");
   a_ptr_kept: assert property (
      (tableBusy && !ptrWrLow && !ptrWrHigh) |=> $stable(tableAddr))
      else $error("pointer moved by table read");
   a_pin_owner: assert property (
      serOwns |=> progSerialDataOe == $past(serOe))
      else $error("shared function drove debug pin");
   a_serial_prog_write: assert property (
      (wrNow && !serRead && !serTgt && serAddr <= PROG_LAST)
      |=> progMem[$past(serAddr)] == $past(shiftIn[15:0]))
      else $error("serial write not stored");
   c_ordinary_read: cover property (accept && !tabrdExt ##[6:9] destWrEn);
   c_extended_read: cover property (
      accept && tabrdExt && destSector != SECTOR_ZERO);
   c_sector_fault: cover property (tabrdFault);
   c_serial_write: cover property (wrNow && !serRead);
   c_serial_read: cover property (progSerialDataOe && progActive);
endmodule : pmtr_top

/* File: verification/pmtr_tool_model.sv */
// Serial programming tool model on the clock and data pins
`timescale 1ns/1ps
module pmtr_tool_model (
   input wire logic sys_clk,
   input wire logic devOut,
   input wire logic devOe,
   output logic toolClk,
   output logic pinLevel
);
   logic drv;
   logic dat;
   // ==========================================================
   // Pin level: device, else tool, else pull-up
   assign pinLevel = devOe ? devOut : (drv ? dat : 1'b1);
   initial begin
      toolClk = 1'b0;
      drv = 1'b0;
      dat = 1'b0;
   end
   // Half period of eight system clocks
   task automatic half();
      repeat (8) @(posedge sys_clk);
      #5;
   endtask : half
   // One frame of 34 bits, most significant first
   task automatic frame(input logic rd, input logic tgt,
         input logic [15:0] addr, input logic [15:0] wd,
         output logic [15:0] rdat);
      logic [33:0] bits;
      bits = {rd, tgt, addr, wd};
      rdat = 16'h0000;
      for (int i = 33; i >= 0; i--) begin
         drv = !(rd && i < 16);
         dat = bits[i];
         half();
         toolClk = 1'b1;
         if (rd && i == 16)
            drv = 1'b0;
         half();
         if (rd && i >= 1 && i <= 16)
            rdat[i - 1] = pinLevel;
         toolClk = 1'b0;
      end
      drv = 1'b0;
      half();
   endtask : frame
endmodule : pmtr_tool_model

/* File: verification/program_memory_table_read_bench.sv */
// Self-checking bench for the program memory and table read block
`timescale 1ns/1ps
module program_memory_table_read_bench import pmtr_pkg::*; ;
   logic sys_clk = 1'b0, arst_n = 1'b0, pcLoad = 1'b0;
   logic [15:0] pcTarget = 16'h0000, progCounter, fetchWord, r;
   logic ptrWrLow = 1'b0, ptrWrHigh = 1'b0, tabrdReq = 1'b0;
   logic [7:0] ptrWrData = 8'h00, tablePtrLow, tablePtrHigh;
   logic tabrdExt = 1'b0, tableBusy, tabrdFault, destWrEn;
   logic [10:0] tabrdDest = 11'h000, destWrAddr;
   logic [7:0] destWrData, latchWrData = 8'h00, tableDataHighLatch;
   logic latchWrEn = 1'b0, progEntryPin = 1'b0, debugMode = 1'b0;
   logic toolClk, pinLevel, dOut, dOe, sfOut = 1'b0, sfOe = 1'b0;
   logic cycleTick, progActive;
   int miscompares = 0, checksDone = 0, cycles = 0;
   always #50 sys_clk = ~sys_clk;
   pmtr_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .pcLoad(pcLoad),
      .pcTarget(pcTarget), .cycleTick(cycleTick),
      .progCounter(progCounter), .fetchWord(fetchWord),
      .ptrWrLow(ptrWrLow), .ptrWrHigh(ptrWrHigh), .ptrWrData(ptrWrData),
      .tablePtrLow(tablePtrLow), .tablePtrHigh(tablePtrHigh),
      .tabrdReq(tabrdReq), .tabrdExt(tabrdExt), .tabrdDest(tabrdDest),
      .tableBusy(tableBusy), .tabrdFault(tabrdFault),
      .destWrEn(destWrEn), .destWrAddr(destWrAddr),
      .destWrData(destWrData), .latchWrEn(latchWrEn),
      .latchWrData(latchWrData), .tableDataHighLatch(tableDataHighLatch),
      .progEntryPin(progEntryPin), .debugMode(debugMode),
      .progSerialClockPin(toolClk), .progSerialDataIn(pinLevel),
      .progSerialDataOut(dOut), .progSerialDataOe(dOe),
      .sharedFuncOut(sfOut), .sharedFuncOe(sfOe), .progActive(progActive));
   pmtr_tool_model tool (.sys_clk(sys_clk), .devOut(dOut), .devOe(dOe),
      .toolClk(toolClk), .pinLevel(pinLevel));
   // ==========================================================
   // Shared tasks
   task automatic step();
      @(posedge sys_clk);
      #5;
   endtask : step
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic waitTick();
      for (int n = 0; n < 8 && cycleTick !== 1'b1; n++)
         step();
      step();
   endtask : waitTick
   task automatic setPtr(input logic [7:0] hi, input logic [7:0] lo);
      ptrWrHigh = 1'b1;
      ptrWrData = hi;
      step();
      ptrWrHigh = 1'b0;
      ptrWrLow = 1'b1;
      ptrWrData = lo;
      step();
      ptrWrLow = 1'b0;
   endtask : setPtr
   task automatic tread(input logic ext, input logic [10:0] dst,
         input logic [15:0] exp);
      int n;
      tabrdExt = ext;
      tabrdDest = dst;
      tabrdReq = 1'b1;
      step();
      tabrdReq = 1'b0;
      chk("busy", 16'h0001, {15'h0000, tableBusy});
      n = 0;
      while (destWrEn !== 1'b1 && n < 12) begin
         step();
         n++;
      end
      chk("latency", 16'h0001, {15'h0000, n >= 5 && n <= 8});
      chk("idle", 16'h0000, {15'h0000, tableBusy});
      chk("dest", {5'h00, dst}, {5'h00, destWrAddr});
      chk("low", {8'h00, exp[7:0]}, {8'h00, destWrData});
      chk("high", {8'h00, exp[15:8]}, {8'h00, tableDataHighLatch});
   endtask : tread
   // ==========================================================
   // Scenarios
   task automatic t_fetch();
      chk("pc reset", RESET_VECTOR, progCounter);
      repeat (3) waitTick();
      chk("pc count", 16'h0003, progCounter);
      repeat (3) step();
      chk("tick", 16'h0001, {15'h0000, cycleTick});
      pcLoad = 1'b1;
      pcTarget = PROG_LAST;
      waitTick();
      pcLoad = 1'b0;
      chk("pc load", PROG_LAST, progCounter);
      waitTick();
      chk("pc wrap", 16'h0000, progCounter);
      $display("fetch done");
   endtask : t_fetch
   task automatic t_prog();
      progEntryPin = 1'b1;
      repeat (6) step();
      chk("active", 16'h0001, {15'h0000, progActive});
      tool.frame(1'b0, 1'b0, 16'hB006, 16'h3C1A, r);
      tool.frame(1'b0, 1'b0, 16'hB005, 16'h5A0F, r);
      tool.frame(1'b1, 1'b0, 16'hB006, 16'h0000, r);
      chk("serial prog", 16'h3C1A, r);
      tool.frame(1'b0, 1'b1, 16'h0010, 16'h0077, r);
      tool.frame(1'b1, 1'b1, 16'h0010, 16'h0000, r);
      chk("serial data", 16'h0077, r);
      progEntryPin = 1'b0;
      repeat (6) step();
      $display("serial done");
   endtask : t_prog
   task automatic t_table();
      pcLoad = 1'b1;
      pcTarget = 16'hB006;
      waitTick();
      pcLoad = 1'b0;
      waitTick();
      chk("fetch", 16'h3C1A, fetchWord);
      setPtr(8'hB0, 8'h06);
      tread(1'b0, 11'h020, 16'h3C1A);
      chk("ptr", 16'hB006, {tablePtrHigh, tablePtrLow});
      setPtr(8'hB0, 8'h05);
      tread(1'b1, 11'h220, 16'h5A0F);
      chk("ptr ext", 16'hB005, {tablePtrHigh, tablePtrLow});
      setPtr(8'hFF, 8'hFF);
      tread(1'b1, 11'h730, 16'h0000);
      $display("table done");
   endtask : t_table
   task automatic t_fault();
      logic bad;
      bad = 1'b0;
      tabrdExt = 1'b0;
      tabrdDest = 11'h120;
      tabrdReq = 1'b1;
      step();
      tabrdReq = 1'b0;
      chk("fault", 16'h0001, {15'h0000, tabrdFault});
      repeat (10) begin
         bad = bad | (destWrEn !== 1'b0) | (tableBusy !== 1'b0);
         step();
      end
      chk("refused", 16'h0000, {15'h0000, bad});
      $display("fault done");
   endtask : t_fault
   task automatic t_latch();
      latchWrEn = 1'b1;
      latchWrData = 8'hA5;
      step();
      latchWrEn = 1'b0;
      chk("latch wr", 16'h00A5, {8'h00, tableDataHighLatch});
      setPtr(8'hB0, 8'h06);
      tread(1'b0, 11'h040, 16'h3C1A);
      latchWrEn = 1'b1;
      step();
      latchWrEn = 1'b0;
      chk("latch back", 16'h00A5, {8'h00, tableDataHighLatch});
      $display("latch done");
   endtask : t_latch
   task automatic t_debug();
      debugMode = 1'b1;
      sfOe = 1'b1;
      sfOut = 1'b1;
      repeat (6) step();
      chk("shared off", 16'h0000, {15'h0000, dOe});
      tool.frame(1'b1, 1'b0, 16'hB005, 16'h0000, r);
      chk("debug read", 16'h5A0F, r);
      debugMode = 1'b0;
      repeat (6) step();
      chk("shared on", 16'h0003, {14'h0000, dOe, dOut});
      sfOe = 1'b0;
      $display("debug done");
   endtask : t_debug
   // ==========================================================
   // Closing report and hang limit
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      #5;
      arst_n = 1'b1;
      t_fetch();
      t_prog();
      t_table();
      t_fault();
      t_latch();
      t_debug();
      stop_test();
   end
endmodule : program_memory_table_read_bench
